/* File: hdl/pmc_consts.svh */
`ifndef PMC_CONSTS_SVH
`define PMC_CONSTS_SVH

// register byte addresses
`define PMC_ADDR_MODE_CFG 32'h4040_0000
`define PMC_ADDR_SRAM_PD 32'h4040_0004
`define PMC_ADDR_CAUSE 32'h4040_0008
// extra registers: peripheral clock gates, scratch
`define PMC_ADDR_CLK_GATE 32'h4040_000c
`define PMC_ADDR_SCRATCH 32'h4040_0010

// field positions
`define PMC_MODE_LO 0
`define PMC_MODE_HI 1
`define PMC_PAD_HOLD_BIT 2
`define PMC_SMALL_BANK_BIT 0
`define PMC_LARGE_BANK_BIT 1
`define PMC_WDOG_BIT 0
`define PMC_HIB_BIT 1
`define PMC_SHUT_BIT 2
`define PMC_DBG_BIT 3

// reset values
`define PMC_MODE_CFG_RST 3'h0
`define PMC_SRAM_PD_RST 2'h0
`define PMC_CAUSE_RST 3'h0
`define PMC_CLK_GATE_RST 16'h0000
`define PMC_SCRATCH_RST 32'h0000_0000

// timing
`define PMC_CLK_MHZ 40
`define PMC_HIB_WAKE_US 320
`define PMC_HIB_WAKE_CYC (`PMC_HIB_WAKE_US * `PMC_CLK_MHZ)
`define PMC_CORE_RST_CYC 4

`endif

/* File: hdl/pmc_pkg.sv */
package pmc_pkg;

    typedef enum logic [2:0] {
        PMC_RUN = 3'b000,
        PMC_SLEEP = 3'b001,
        PMC_HIB = 3'b010,
        PMC_SHUT = 3'b011,
        PMC_WAKE = 3'b100
    } pmc_state_t;

    // power and clock controls toward the rest of the chip
    typedef struct packed {
        logic core_clk_on;
        logic flash_pwr_on;
        logic core_pwr_on;
        logic periph_pwr_on;
        logic fast_osc_on;
        logic fast_osc_hi;
        logic core_rst;
    } pmc_ctrl_t;

    typedef struct packed {
        logic wake_timer;
        logic gpio;
        logic ext_rst;
        logic irq;
        logic shut_pin;
    } pmc_wake_t;

endpackage

/* File: hdl/pmc_power_mode_controller.sv */
`include "pmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module pmc_power_mode_controller #(
    parameter int unsigned HIB_WAKE_CYC = `PMC_HIB_WAKE_CYC
) (
    // clock and synchronous reset
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [31:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // core, debug pin and oscillator side
    input wire logic i_wait_instr,
    input wire logic i_debug_enable_pin,
    input wire logic i_slow_rc_oscillator_en,
    input wire logic i_fast_osc_keep,
    input wire logic i_watchdog_reset,
    // wake sources
    input wire pmc_pkg::pmc_wake_t i_wake,
    // controls toward the rest of the chip
    output pmc_pkg::pmc_ctrl_t o_ctrl,
    output pmc_pkg::pmc_state_t o_state,
    output logic o_large_bank_off,
    output logic o_small_bank_off,
    output logic o_pad_hold,
    output logic o_slow_clk_only,
    output logic [15:0] o_periph_clk_gate
);

    pmc_pkg::pmc_state_t state;
    pmc_pkg::pmc_state_t next_state;
    logic [1:0] mode_sel;
    logic pad_hold;
    logic [1:0] bank_off;
    logic [15:0] clk_gate;
    logic [31:0] scratch;
    logic watchdog_reset_flag;
    logic hibernate_wake_flag;
    logic shutdown_wake_flag;
    logic [31:0] wake_cnt;
    logic woke_from_shut;

    // apb decode
    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    wire hit_mode = i_paddr == `PMC_ADDR_MODE_CFG;
    wire hit_pd = i_paddr == `PMC_ADDR_SRAM_PD;
    wire hit_cause = i_paddr == `PMC_ADDR_CAUSE;
    wire hit_gate = i_paddr == `PMC_ADDR_CLK_GATE;
    wire hit_scr = i_paddr == `PMC_ADDR_SCRATCH;
    wire hit_any = hit_mode | hit_pd | hit_cause | hit_gate | hit_scr;
    wire [31:0] rd_mode = {29'h0, pad_hold, mode_sel};
    wire [31:0] rd_pd = {30'h0, bank_off};
    wire [31:0] rd_cause = {28'h0, i_debug_enable_pin,
        shutdown_wake_flag, hibernate_wake_flag, watchdog_reset_flag};
    wire [31:0] rd_data = hit_mode ? rd_mode :
        hit_pd ? rd_pd :
        hit_cause ? rd_cause :
        hit_gate ? {16'h0, clk_gate} :
        hit_scr ? scratch : 32'h0000_0000;

    // wake and entry conditions
    wire dbg = i_debug_enable_pin;
    wire enter_lp = i_wait_instr & ~dbg;
    wire hib_wake = dbg | i_wake.wake_timer | i_wake.gpio
        | i_wake.ext_rst;
    wire shut_wake = dbg | i_wake.shut_pin | i_wake.ext_rst;
    wire wake_done = wake_cnt >= HIB_WAKE_CYC - 1;

    // mode transitions
    always_comb begin
        next_state = state;
        unique case (state)
            pmc_pkg::PMC_RUN: begin
                if (enter_lp) begin
                    // field sampled as the wait executes
                    if (mode_sel[1]) begin
                        next_state = pmc_pkg::PMC_SHUT;
                    end else if (mode_sel[0]) begin
                        next_state = pmc_pkg::PMC_HIB;
                    end else begin
                        next_state = pmc_pkg::PMC_SLEEP;
                    end
                end
            end
            pmc_pkg::PMC_SLEEP: begin
                if (i_wake.irq | dbg) begin
                    next_state = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_HIB: begin
                if (hib_wake) begin
                    next_state = pmc_pkg::PMC_WAKE;
                end
            end
            pmc_pkg::PMC_SHUT: begin
                if (shut_wake) begin
                    next_state = pmc_pkg::PMC_WAKE;
                end
            end
            pmc_pkg::PMC_WAKE: begin
                if (wake_done) begin
                    next_state = pmc_pkg::PMC_RUN;
                end
            end
            default: next_state = pmc_pkg::PMC_RUN;
        endcase
    end

    wire entering_wake = next_state == pmc_pkg::PMC_WAKE
        && state != pmc_pkg::PMC_WAKE;

    // state register; power logic is not reset by deep-mode exit
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            state <= pmc_pkg::PMC_RUN;
        end else begin
            state <= next_state;
        end
    end

    // wake sequence timer
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N || state != pmc_pkg::PMC_WAKE) begin
            wake_cnt <= 32'h0000_0000;
        end else begin
            wake_cnt <= wake_cnt + 32'h0000_0001;
        end
    end

    // remember which deep mode is being left
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            woke_from_shut <= 1'b0;
        end else if (entering_wake) begin
            woke_from_shut <= state == pmc_pkg::PMC_SHUT;
        end
    end

    // reset image of the mode register, split into its fields
    wire [2:0] mode_cfg_rst = `PMC_MODE_CFG_RST;
    wire mode_wr = wr && hit_mode;

    // mode field register, cleared as a deep mode is left
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            mode_sel <= mode_cfg_rst[`PMC_MODE_HI:`PMC_MODE_LO];
        end else if (entering_wake) begin
            mode_sel <= 2'h0; // software must choose again
        end else if (mode_wr) begin
            mode_sel <= i_pwdata[`PMC_MODE_HI:`PMC_MODE_LO];
        end
    end

    // pad hold bit: the wake event wins over a software write
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            pad_hold <= mode_cfg_rst[`PMC_PAD_HOLD_BIT];
        end else if (entering_wake) begin
            pad_hold <= 1'b1;
        end else if (mode_wr) begin
            pad_hold <= i_pwdata[`PMC_PAD_HOLD_BIT];
        end
    end

    // sram bank power-down register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            bank_off <= `PMC_SRAM_PD_RST;
        end else if (wr && hit_pd) begin
            bank_off <= i_pwdata[1:0];
        end
    end

    // peripheral clock gate register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            clk_gate <= `PMC_CLK_GATE_RST;
        end else if (wr && hit_gate) begin
            clk_gate <= i_pwdata[15:0];
        end
    end

    // always-on scratch, untouched by mode changes
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            scratch <= `PMC_SCRATCH_RST;
        end else if (wr && hit_scr) begin
            scratch <= i_pwdata;
        end
    end

    // reset cause: the watchdog pulse wins over a finishing wake
    wire [2:0] cause_rst = `PMC_CAUSE_RST;
    wire wake_finish = state == pmc_pkg::PMC_WAKE && wake_done;

    // last reset came from the watchdog
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            watchdog_reset_flag <= cause_rst[`PMC_WDOG_BIT];
        end else if (i_watchdog_reset) begin
            watchdog_reset_flag <= 1'b1;
        end else if (wake_finish) begin
            watchdog_reset_flag <= 1'b0;
        end
    end

    // last reset was a wake from hibernate
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            hibernate_wake_flag <= cause_rst[`PMC_HIB_BIT];
        end else if (i_watchdog_reset) begin
            hibernate_wake_flag <= 1'b0;
        end else if (wake_finish) begin
            hibernate_wake_flag <= ~woke_from_shut;
        end
    end

    // last reset was a wake from shutdown
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            shutdown_wake_flag <= cause_rst[`PMC_SHUT_BIT];
        end else if (i_watchdog_reset) begin
            shutdown_wake_flag <= 1'b0;
        end else if (wake_finish) begin
            shutdown_wake_flag <= woke_from_shut;
        end
    end

    // power and clock outputs per mode
    wire in_run = state == pmc_pkg::PMC_RUN;
    wire in_sleep = state == pmc_pkg::PMC_SLEEP;
    wire in_wake = state == pmc_pkg::PMC_WAKE;
    wire deep = state == pmc_pkg::PMC_HIB || state == pmc_pkg::PMC_SHUT;
    wire in_shut = state == pmc_pkg::PMC_SHUT;
    pmc_pkg::pmc_ctrl_t next_ctrl;
    always_comb begin
        next_ctrl.core_clk_on = in_run;
        next_ctrl.flash_pwr_on = in_run | in_wake;
        next_ctrl.core_pwr_on = ~deep;
        next_ctrl.periph_pwr_on = ~deep;
        next_ctrl.fast_osc_on = in_run | in_wake
            | (in_sleep & i_fast_osc_keep);
        next_ctrl.fast_osc_hi = 1'b0; // low setting selects 40 MHz
        next_ctrl.core_rst = deep | in_wake;
    end

    // next values of the single-bit outputs
    wire next_large_bank_off = bank_off[`PMC_LARGE_BANK_BIT]
        | in_shut;
    wire next_small_bank_off = bank_off[`PMC_SMALL_BANK_BIT]
        | in_shut;
    wire next_slow_clk_only = state == pmc_pkg::PMC_HIB
        && i_slow_rc_oscillator_en;

    // controls toward clocks, supplies and core reset
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_ctrl <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
        end else begin
            o_ctrl <= next_ctrl;
        end
    end

    // visible mode, one cycle behind the state register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_state <= pmc_pkg::PMC_RUN;
        end else begin
            o_state <= state;
        end
    end

    // large bank supply switch
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_large_bank_off <= 1'b0;
        end else begin
            o_large_bank_off <= next_large_bank_off;
        end
    end

    // small bank supply switch
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_small_bank_off <= 1'b0;
        end else begin
            o_small_bank_off <= next_small_bank_off;
        end
    end

    // pad latch toward the io ring
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_pad_hold <= 1'b0;
        end else begin
            o_pad_hold <= pad_hold;
        end
    end

    // slow oscillator as the only clock in hibernate
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_slow_clk_only <= 1'b0;
        end else begin
            o_slow_clk_only <= next_slow_clk_only;
        end
    end

    // peripheral clock gates
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_periph_clk_gate <= `PMC_CLK_GATE_RST;
        end else begin
            o_periph_clk_gate <= clk_gate;
        end
    end

    // apb slave: the answer is registered off the setup cycle
    wire setup = i_psel & ~i_penable;
    wire next_pslverr = setup & (~hit_any | (i_pwrite & hit_cause));
    wire [31:0] next_prdata = (setup & ~i_pwrite) ? rd_data
        : 32'h0000_0000;

    // ready pulse in the first access cycle, no wait states
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_pready <= 1'b0;
        end else begin
            o_pready <= setup;
        end
    end

    // error pulse: unmapped address or write to the status register
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_pslverr <= 1'b0;
        end else begin
            o_pslverr <= next_pslverr;
        end
    end

    // read data stands with the ready pulse only
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_N) begin
            o_prdata <= 32'h0000_0000;
        end else begin
            o_prdata <= next_prdata;
        end
    end

endmodule

`default_nettype wire

/* File: testbench/pmc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_core_model (
    input wire logic clk,
    output logic wait_instr,
    output logic fast_keep,
    output pmc_pkg::pmc_wake_t wake
);
    // idle core, no wake source active
    initial begin
        wait_instr = 1'b0;
        fast_keep = 1'b0;
        wake = '0;
    end
    // wfi/wfe pulse, only issued after the mode is configured
    task automatic exec_wait();
        @(posedge clk) wait_instr <= 1'b1;
        @(posedge clk) wait_instr <= 1'b0;
    endtask
    // one-cycle event from a wake source, bit index into the struct
    task automatic raise(input int b);
        @(posedge clk) wake[b] <= 1'b1;
        @(posedge clk) wake[b] <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* File: testbench/pmc_power_mode_controller_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module pmc_checker #(
    parameter int unsigned HIB_WAKE_CYC = 8
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_N,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [31:0] i_paddr,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic i_wait_instr,
    input wire logic i_debug_enable_pin,
    input wire logic i_slow_rc_oscillator_en,
    input wire pmc_pkg::pmc_wake_t i_wake,
    input wire pmc_pkg::pmc_ctrl_t o_ctrl,
    input wire pmc_pkg::pmc_state_t o_state,
    input wire logic o_pad_hold,
    input wire logic o_slow_clk_only
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RST_N);
    // wake duration counter
    int unsigned wcnt;
    wire logic in_wake = o_state == pmc_pkg::PMC_WAKE;
    wire logic in_hib = o_state == pmc_pkg::PMC_HIB;
    wire logic unmapped = i_paddr[31:8] == 24'h404000 && i_paddr[7:0] > 8'h10;
    wire logic hib_src = i_wake.wake_timer | i_wake.gpio | i_wake.ext_rst;
    always_ff @(posedge I_CLOCK) begin
        wcnt <= (!I_RST_N || !in_wake) ? 0 : wcnt + 1;
    end
    sequence s_wake;
        ##2 in_wake ##[0:2] o_pad_hold;
    endsequence
    property p_pready;
        i_psel && !i_penable |=> o_pready;
    endproperty
    property p_slverr;
        o_pready && unmapped |-> o_pslverr;
    endproperty
    property p_dbg;
        i_debug_enable_pin |-> ##2 o_state inside {pmc_pkg::PMC_RUN,
            pmc_pkg::PMC_WAKE};
    endproperty
    property p_wait;
        i_wait_instr && !i_debug_enable_pin && o_state == pmc_pkg::PMC_RUN
            |-> ##2 o_state != pmc_pkg::PMC_RUN;
    endproperty
    property p_sleep;
        (o_state == pmc_pkg::PMC_SLEEP)[*3] |->
            !$past(o_ctrl.core_clk_on) && !$past(o_ctrl.flash_pwr_on);
    endproperty
    property p_hib;
        in_hib[*3] |-> !$past(o_ctrl.core_pwr_on) && $past(o_ctrl.core_rst);
    endproperty
    property p_slow;
        in_hib[*3] |-> o_slow_clk_only == i_slow_rc_oscillator_en;
    endproperty
    property p_hib_wake;
        in_hib && hib_src |-> s_wake;
    endproperty
    property p_wake_len;
        in_wake |-> wcnt < HIB_WAKE_CYC + 2;
    endproperty
    property p_wake_end;
        $fell(in_wake) |-> o_state == pmc_pkg::PMC_RUN;
    endproperty
    a_pready: assert property (p_pready) else $error("no ready");
    a_slverr: assert property (p_slverr) else $error("no slverr");
    a_dbg: assert property (p_dbg) else $error("low power in debug");
    a_wait: assert property (p_wait) else $error("wait ignored");
    a_sleep: assert property (p_sleep) else $error("sleep ctrl");
    a_hib: assert property (p_hib) else $error("hibernate ctrl");
    a_slow: assert property (p_slow) else $error("slow clock");
    a_hib_wake: assert property (p_hib_wake) else $error("no wake");
    a_wake_len: assert property (p_wake_len) else $error("long wake");
    a_wake_end: assert property (p_wake_end) else $error("bad exit");
endmodule
bind pmc_power_mode_controller pmc_checker #(.HIB_WAKE_CYC(HIB_WAKE_CYC))
    chk_i (.I_CLOCK, .I_RST_N, .i_psel, .i_penable, .i_paddr, .o_pready,
    .o_pslverr, .i_wait_instr, .i_debug_enable_pin, .i_slow_rc_oscillator_en,
    .i_wake, .o_ctrl, .o_state, .o_pad_hold, .o_slow_clk_only);
`default_nettype wire

/* File: testbench/power_mode_controller_bench.sv */
`include "pmc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module power_mode_controller_bench;
    localparam int HW = 8;
    logic clk = 0, rst_n = 0, sel = 0, en = 0, wr = 0, dbg = 0, slow = 1;
    logic wdog = 0, rdy, err, e, lg, sm, ph, so, wi, fk;
    logic [31:0] addr = '0, wd = '0, rd, r, sc, v;
    logic [15:0] gate;
    pmc_pkg::pmc_wake_t wk;
    pmc_pkg::pmc_ctrl_t ctrl;
    pmc_pkg::pmc_state_t st;
    int num_errors = 0, checks_done = 0, cyc = 0, seed = 32'h41a1, n;
    always #12.5 clk = ~clk;
    pmc_core_model core (.clk(clk), .wait_instr(wi), .fast_keep(fk),
        .wake(wk));
    pmc_power_mode_controller #(.HIB_WAKE_CYC(HW)) uut (.I_CLOCK(clk),
        .I_RST_N(rst_n), .i_psel(sel), .i_penable(en), .i_pwrite(wr),
        .i_paddr(addr), .i_pwdata(wd), .o_prdata(rd), .o_pready(rdy),
        .o_pslverr(err), .i_wait_instr(wi), .i_debug_enable_pin(dbg),
        .i_slow_rc_oscillator_en(slow), .i_fast_osc_keep(fk),
        .i_watchdog_reset(wdog), .i_wake(wk), .o_ctrl(ctrl), .o_state(st),
        .o_large_bank_off(lg), .o_small_bank_off(sm), .o_pad_hold(ph),
        .o_slow_clk_only(so), .o_periph_clk_gate(gate));
    // compare and count
    task automatic chk(input string nm, input logic [31:0] s, x);
        checks_done++;
        if (s !== x) begin
            num_errors++;
            $display("wrong value %s exp %h seen %h", nm, x, s);
        end
    endtask
    // apb transfer, held until ready is sampled
    task automatic apb(input logic w, input logic [31:0] a, d,
        output logic [31:0] q, output logic qe);
        @(posedge clk);
        sel <= 1; wr <= w; addr <= a; wd <= d;
        @(posedge clk);
        en <= 1;
        do @(posedge clk); while (rdy !== 1'b1);
        q = rd;
        qe = err;
        sel <= 0;
        en <= 0;
    endtask
    // expected state after a wait instruction
    function automatic pmc_pkg::pmc_state_t want(input logic [1:0] m, d);
        if (d) return pmc_pkg::PMC_RUN;
        return m[1] ? pmc_pkg::PMC_SHUT : m[0] ? pmc_pkg::PMC_HIB :
            pmc_pkg::PMC_SLEEP;
    endfunction
    task automatic go(input logic [1:0] m, input pmc_pkg::pmc_state_t x);
        apb(1, `PMC_ADDR_MODE_CFG, {30'h0, m}, r, e);
        core.exec_wait();
        repeat (2) @(posedge clk);
        #1 chk("state", st, x);
    endtask
    task automatic to_run();
        n = 0;
        while (st !== pmc_pkg::PMC_RUN && n < 40) begin
            @(posedge clk) #1 n++;
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (2) @(posedge clk);
        rst_n <= 1;
        #1 chk("ctrl", ctrl, 32'h7c);
        chk("state", st, pmc_pkg::PMC_RUN);
        for (int i = 0; i < 3; i++) begin
            apb(0, 32'h4040_0000 + 4 * i, 0, r, e);
            chk("reset", r, 0);
        end
        repeat (4) begin
            v = $random(seed);
            apb(1, `PMC_ADDR_SRAM_PD, v, r, e);
            apb(1, `PMC_ADDR_CLK_GATE, v, r, e);
            @(posedge clk) #1 chk("banks", {lg, sm}, v[1:0]);
            chk("gates", gate, v[15:0]);
            apb(0, `PMC_ADDR_SRAM_PD, 0, r, e);
            chk("pd", r, v[1:0]);
        end
        apb(0, 32'h4040_0020, 0, r, e);
        chk("err", e, 1);
        apb(1, `PMC_ADDR_CAUSE, '1, r, e);
        chk("ro err", e, 1);
        $display("register test done");
        dbg <= 1;
        go(2'b01, want(2'b01, 1));
        apb(0, `PMC_ADDR_CAUSE, 0, r, e);
        chk("dbg", r, 32'h8);
        dbg <= 0;
        core.fast_keep <= $random(seed);
        go(2'b00, want(2'b00, 0));
        chk("sleep", {ctrl.core_clk_on, ctrl.flash_pwr_on}, 0);
        chk("fastosc", ctrl.fast_osc_on, fk);
        core.raise(1);
        to_run();
        chk("irq", st, pmc_pkg::PMC_RUN);
        $display("debug and sleep test done");
        for (int k = 0; k < 5; k++) begin
            logic [1:0] m;
            m = k < 3 ? 2'b01 : {1'b1, k[0]};
            sc = $random(seed);
            slow <= sc[0];
            apb(1, `PMC_ADDR_SCRATCH, sc, r, e);
            go(m, want(m, 0));
            chk("bank", {lg, sm}, m[1] ? 2'b11 : v[1:0]);
            chk("power", ctrl[5:3], 0);
            if (!m[1]) chk("slowclk", so, sc[0]);
            core.raise(k < 3 ? 4 - k : 0);
            @(posedge clk) #1 chk("hold", ph, 1);
            to_run();
            if (!m[1]) chk("len", n >= HW - 1 && n <= HW + 2, 1);
            apb(0, `PMC_ADDR_CAUSE, 0, r, e);
            chk("cause", r, m[1] ? 4 : 2);
            apb(0, `PMC_ADDR_SCRATCH, 0, r, e);
            chk("scratch", r, sc);
            chk("reboot", ctrl[1:0], 0);
            apb(0, `PMC_ADDR_MODE_CFG, 0, r, e);
            chk("mode", r, 4);
            $display("deep mode test done");
        end
        wdog <= 1;
        @(posedge clk) wdog <= 0;
        apb(0, `PMC_ADDR_CAUSE, 0, r, e);
        chk("wdog", r, 1);
        $display("watchdog test done");
        give_verdict();
    end
endmodule
`default_nettype wire
